// ### rtl/phyp_port.sv
// PHY port and transceiver pins with a small control bus register file.
// Assumes all inputs synchronous to CLOCK; pads resolve the open-drain
// and two-way pins from the enables.
`timescale 1ns/100ps
module phyp_port
    import phyp_pkg::*;
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic NRST,
    // Transceiver side.
    input wire logic SERIAL_RX_IN,
    input wire logic CARRIER_PRESENT_IN,
    output logic SERIAL_TX_OUT,
    input wire logic TX_ENABLE_POLARITY,
    output logic PMD_TX_ENABLE_OUT,
    // Indicate path.
    output logic INDICATE_PARITY,
    output logic INDICATE_CTL_FLAG,
    output logic [7:0] INDICATE_SYMBOLS,
    // Request path.
    input wire logic REQUEST_VALID,
    output logic REQUEST_READY,
    input wire logic REQUEST_PARITY,
    input wire logic REQUEST_CTL_FLAG,
    input wire logic [7:0] REQUEST_SYMBOLS,
    // Control bus.
    input wire logic CE_N,
    input wire logic READ_NOT_WRITE,
    input wire logic [5:0] CB_ADDR,
    input wire logic [7:0] CB_DATA_I,
    output logic [7:0] CB_DATA_O,
    output logic CB_DATA_OE,
    input wire logic CB_PARITY_I,
    output logic CB_PARITY_O,
    output logic CB_PARITY_OE,
    output logic ACK_N_O,
    output logic ACK_N_OE
);

    logic tx_drive_permit_r;
    logic [2:0] tx_state_code_r;
    logic req_perr_r;
    logic ack_r;
    logic bus_take;
    logic wr_ok;
    logic [7:0] rd_val;
    logic off_transmit_state;
    logic req_bad;
    logic fifo_valid;
    logic fifo_pop;
    logic [8:0] fifo_data;
    logic [3:0] tx_cnt_r;
    logic [9:0] tx_shift_r;
    logic [3:0] rx_cnt_r;
    logic [8:0] rx_shift_r;

    // ****************************************************************
    // Control bus slave.
    // ****************************************************************
    // An access is taken once per low period of CE_N; the ack then holds
    // until CE_N rises, so a slow host cannot trigger a second write.
    assign bus_take = !CE_N && !ack_r;
    assign wr_ok = bus_take && !READ_NOT_WRITE
        && (CB_PARITY_I == odd_parity(1'b0, CB_DATA_I));

    // Read multiplexer; reserved and unmapped offsets read as zero.
    always_comb begin
        rd_val = 8'h00;
        unique case (CB_ADDR)
            MODE_OFS: rd_val[MODE_PERMIT_BIT] = tx_drive_permit_r;
            TX_STATE_OFS: rd_val[2:0] = tx_state_code_r;
            STATUS_OFS: begin
                rd_val[STAT_CARRIER_BIT] = CARRIER_PRESENT_IN;
                rd_val[STAT_PERR_BIT] = req_perr_r;
                rd_val[STAT_FULL_BIT] = !REQUEST_READY;
                rd_val[STAT_EMPTY_BIT] = !fifo_valid;
            end
            default: rd_val = 8'h00;
        endcase
    end

    // Handshake and read data pins.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            ack_r <= 1'b0;
            ACK_N_O <= 1'b1;
            ACK_N_OE <= 1'b0;
            CB_DATA_O <= 8'h00;
            CB_DATA_OE <= 1'b0;
            CB_PARITY_O <= 1'b1;
            CB_PARITY_OE <= 1'b0;
        end else if (CE_N) begin
            ack_r <= 1'b0;
            ACK_N_O <= 1'b1;
            ACK_N_OE <= 1'b0;
            CB_DATA_OE <= 1'b0;
            CB_PARITY_OE <= 1'b0;
        end else if (bus_take) begin
            ack_r <= 1'b1;
            ACK_N_O <= 1'b0;
            ACK_N_OE <= 1'b1;
            CB_DATA_O <= rd_val;
            CB_PARITY_O <= odd_parity(1'b0, rd_val);
            CB_DATA_OE <= READ_NOT_WRITE;
            CB_PARITY_OE <= READ_NOT_WRITE;
        end
    end

    // 8-bit registers at 6-bit addresses; reserved offsets ignore writes.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            tx_drive_permit_r <= MODE_PERMIT_RST;
            tx_state_code_r <= TX_STATE_RST;
        end else if (wr_ok) begin
            if (CB_ADDR == MODE_OFS) begin
                tx_drive_permit_r <= CB_DATA_I[MODE_PERMIT_BIT];
            end
            if (CB_ADDR == TX_STATE_OFS) begin
                tx_state_code_r <= CB_DATA_I[2:0];
            end
        end
    end

    // Sticky request parity error; a new error wins over a write-one clear.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            req_perr_r <= 1'b0;
        end else if (req_bad) begin
            req_perr_r <= 1'b1;
        end else if (wr_ok && CB_ADDR == STATUS_OFS
                && CB_DATA_I[STAT_PERR_BIT]) begin
            req_perr_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Transmitter enable.
    // ****************************************************************
    assign off_transmit_state = (tx_state_code_r == OFF_TRANSMIT_CODE);

    // Output follows polarity only while permitted and transmitting.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            PMD_TX_ENABLE_OUT <= 1'b0;
        end else if (tx_drive_permit_r && !off_transmit_state) begin
            PMD_TX_ENABLE_OUT <= TX_ENABLE_POLARITY;
        end else begin
            PMD_TX_ENABLE_OUT <= !TX_ENABLE_POLARITY;
        end
    end

    // ****************************************************************
    // Request path into the FIFO and out on the serial line.
    // ****************************************************************
    // A pair with bad parity is dropped rather than sent, and flagged.
    assign req_bad = REQUEST_VALID && REQUEST_READY
        && (REQUEST_PARITY != odd_parity(REQUEST_CTL_FLAG, REQUEST_SYMBOLS));
    assign fifo_pop = fifo_valid && (tx_cnt_r == FRAME_LAST);

    phyp_fifo #(
        .WIDTH(PAIR_W),
        .DEPTH(FIFO_DEPTH)
    ) u_req_fifo (
        .clk(CLOCK),
        .rst_n(NRST),
        .in_valid(REQUEST_VALID && !req_bad),
        .in_ready(REQUEST_READY),
        .in_data({REQUEST_CTL_FLAG, REQUEST_SYMBOLS}),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // One pair per ten line bits; idle pairs fill gaps in the stream.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            tx_cnt_r <= 4'h0;
            tx_shift_r <= 10'h000;
        end else if (tx_cnt_r == FRAME_LAST) begin
            tx_cnt_r <= 4'h0;
            if (fifo_valid) begin
                tx_shift_r <= {fifo_data,
                    odd_parity(fifo_data[8], fifo_data[7:0])};
            end else begin
                tx_shift_r <= {IDLE_CTL, IDLE_SYMBOLS,
                    odd_parity(IDLE_CTL, IDLE_SYMBOLS)};
            end
        end else begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            tx_shift_r <= {tx_shift_r[8:0], 1'b0};
        end
    end

    // Line is held low while the transmitter is off.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            SERIAL_TX_OUT <= 1'b0;
        end else begin
            SERIAL_TX_OUT <= tx_shift_r[9] && !off_transmit_state;
        end
    end

    // ****************************************************************
    // Serial receive to the indicate path.
    // ****************************************************************
    // Framing restarts whenever carrier is lost, so data are only
    // trusted while the receiver reports a line signal.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rx_cnt_r <= 4'h0;
            rx_shift_r <= 9'h000;
        end else if (!CARRIER_PRESENT_IN) begin
            rx_cnt_r <= 4'h0;
        end else if (rx_cnt_r == FRAME_LAST) begin
            rx_cnt_r <= 4'h0;
        end else begin
            rx_cnt_r <= rx_cnt_r + 4'h1;
            rx_shift_r <= {rx_shift_r[7:0], SERIAL_RX_IN};
        end
    end

    // Pair outputs change once per pair time and hold for ten clocks.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            INDICATE_CTL_FLAG <= IDLE_CTL;
            INDICATE_SYMBOLS <= IDLE_SYMBOLS;
            INDICATE_PARITY <= odd_parity(IDLE_CTL, IDLE_SYMBOLS);
        end else if (!CARRIER_PRESENT_IN) begin
            INDICATE_CTL_FLAG <= IDLE_CTL;
            INDICATE_SYMBOLS <= IDLE_SYMBOLS;
            INDICATE_PARITY <= odd_parity(IDLE_CTL, IDLE_SYMBOLS);
        end else if (rx_cnt_r == FRAME_LAST) begin
            INDICATE_CTL_FLAG <= rx_shift_r[8];
            INDICATE_SYMBOLS <= rx_shift_r[7:0];
            INDICATE_PARITY <= odd_parity(rx_shift_r[8],
                rx_shift_r[7:0]);
        end
    end

endmodule // phyp_port

// ### rtl/phyp_pkg.sv
// Package of constants, register map and helpers for the PHY port block.
// Assumes one 125 MHz clock and a control bus sampled on that clock.
package phyp_pkg;

    // ****************************************************************
    // Widths and timing.
    // ****************************************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int PAIR_W = 9;               // Control flag and two symbols.
    localparam int FIFO_DEPTH = 32;
    localparam int CLK_MHZ = 125;
    localparam int LINE_MBPS = 125;
    localparam int BITS_PER_CLK = LINE_MBPS / CLK_MHZ;
    localparam int FRAME_BITS = 10;          // Flag, eight symbol bits, parity.
    localparam logic [3:0] FRAME_LAST = 4'h9;

    // ****************************************************************
    // Register map.
    // ****************************************************************
    localparam logic [5:0] MODE_OFS = 6'h00;
    localparam logic [5:0] TX_STATE_OFS = 6'h04;
    localparam logic [5:0] STATUS_OFS = 6'h08;
    localparam logic [5:0] RSVD_LOW_OFS = 6'h3e;
    localparam logic [5:0] RSVD_HIGH_OFS = 6'h3f;
    localparam int MODE_PERMIT_BIT = 0;
    localparam int STAT_CARRIER_BIT = 0;
    localparam int STAT_PERR_BIT = 1;
    localparam int STAT_FULL_BIT = 2;
    localparam int STAT_EMPTY_BIT = 3;
    localparam logic MODE_PERMIT_RST = 1'b0;
    localparam logic [2:0] TX_STATE_RST = 3'h0;
    localparam logic [2:0] OFF_TRANSMIT_CODE = 3'h0;
    localparam logic [7:0] IDLE_SYMBOLS = 8'hff;
    localparam logic IDLE_CTL = 1'b1;

    // Odd parity bit over a control flag and a symbol pair.
    function automatic logic odd_parity(input logic ctl, input logic [7:0] sym);
        odd_parity = ~(^{ctl, sym});
    endfunction

endpackage

// ### rtl/phyp_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock; read data come out of a register.
`timescale 1ns/100ps
module phyp_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Fill side.
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side.
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW-1:0] rd_ptr_nxt;
    logic [AW:0] count_r;
    logic [AW:0] count_nxt;
    logic push;
    logic pop;

    // ****************************************************************
    // Flow control.
    // ****************************************************************
    // Ready is registered so the filling party sees a clean level.
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;
    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'b1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'b1;
        end
    end

    // Occupancy and flags.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            count_r <= count_nxt;
            in_ready <= (count_nxt != (AW+1)'(DEPTH));
            out_valid <= (count_nxt != '0);
        end
    end

    // Pointers.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // Storage has no reset so it can map onto memory cells.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data;
        end
    end

    // Registered read port shows the word at the next head; a word being
    // written to that slot in the same cycle is bypassed, since the memory
    // would still hold the stale word when valid first rises.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_data <= '0;
        end else if (push && wr_ptr_r == rd_ptr_nxt) begin
            out_data <= in_data;
        end else begin
            out_data <= mem_r[rd_ptr_nxt];
        end
    end

endmodule // phyp_fifo

// ### tb/phyp_partner.sv
// Far-side model: a transceiver receiver sending ten-bit frames.
// Assumes the bench clock; frames repeat while the line is on.
`timescale 1ns/100ps
module phyp_partner (
    // Clock.
    input wire logic clk,
    // Frame content.
    input wire logic on,
    input wire logic ctl,
    input wire logic [7:0] sym,
    // Line pins.
    output logic rx,
    output logic carrier
);
    logic [9:0] fr = 10'h000;
    int cnt = 0;

    // One bit per clock, MSB first, carrier high only while sending.
    // A quiet line toggles so a stale bit can never look like data.
    initial begin
        rx = 1'b0;
        carrier = 1'b0;
        forever begin
            @(posedge clk);
            #1;
            if (!on) begin
                carrier = 1'b0;
                rx = ~rx;
                cnt = 0;
            end else begin
                if (cnt == 0) begin
                    fr = {ctl, sym, ~^{ctl, sym}};
                end
                carrier = 1'b1;
                rx = fr[9-cnt];
                cnt = (cnt == 9) ? 0 : cnt + 1;
            end
        end
    end
endmodule // phyp_partner

// ### tb/phyp_port_asserts.sv
// Checker for the port block: bus handshake, enable level, parity.
// Assumes it is bound to phyp_port and sees only its ports.
`timescale 1ns/100ps
module phyp_port_asserts
    import phyp_pkg::*;
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic NRST,
    // Transceiver side.
    input wire logic TX_ENABLE_POLARITY,
    input wire logic PMD_TX_ENABLE_OUT,
    // Indicate path.
    input wire logic INDICATE_PARITY,
    input wire logic INDICATE_CTL_FLAG,
    input wire logic [7:0] INDICATE_SYMBOLS,
    // Control bus.
    input wire logic CE_N,
    input wire logic READ_NOT_WRITE,
    input wire logic [5:0] CB_ADDR,
    input wire logic [7:0] CB_DATA_I,
    input wire logic [7:0] CB_DATA_O,
    input wire logic CB_DATA_OE,
    input wire logic CB_PARITY_I,
    input wire logic CB_PARITY_O,
    input wire logic ACK_N_O,
    input wire logic ACK_N_OE
);
    default clocking cb_clk @(posedge CLOCK); endclocking
    default disable iff (!NRST);

    // ****************************************************************
    // Shadow of the mode and transmit state seen on the bus.
    // ****************************************************************
    logic permit_r;
    logic [2:0] state_r;
    logic pol_r;
    logic [1:0] quiet_r;
    logic take_wr;
    assign take_wr = !CE_N && !ACK_N_OE && !READ_NOT_WRITE
        && (^{CB_PARITY_I, CB_DATA_I});

    // The enable is only judged once config and polarity have settled.
    always_ff @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            permit_r <= MODE_PERMIT_RST;
            state_r <= TX_STATE_RST;
            pol_r <= 1'b0;
            quiet_r <= 2'h0;
        end else begin
            pol_r <= TX_ENABLE_POLARITY;
            if (take_wr && CB_ADDR == MODE_OFS) begin
                permit_r <= CB_DATA_I[MODE_PERMIT_BIT];
            end
            if (take_wr && CB_ADDR == TX_STATE_OFS) begin
                state_r <= CB_DATA_I[2:0];
            end
            if (take_wr || pol_r != TX_ENABLE_POLARITY) begin
                quiet_r <= 2'h0;
            end else if (quiet_r != 2'h3) begin
                quiet_r <= quiet_r + 2'h1;
            end
        end
    end

    // ****************************************************************
    // Assertions.
    // ****************************************************************
    tx_enable_level_a:
        assert property (quiet_r == 2'h3 |-> PMD_TX_ENABLE_OUT ==
            ((permit_r && state_r != OFF_TRANSMIT_CODE) ? pol_r : ~pol_r))
        else $error("Transmit enable level wrong.");
    ind_parity_a:
        assert property (^{INDICATE_PARITY, INDICATE_CTL_FLAG,
            INDICATE_SYMBOLS} == 1'b1)
        else $error("Indicate parity not odd.");
    ack_answer_a:
        assert property (!CE_N && !ACK_N_OE |=> ACK_N_OE && !ACK_N_O)
        else $error("Ack missing one cycle after select.");
    ack_stands_a:
        assert property (ACK_N_OE && !CE_N |=> ACK_N_OE && !ACK_N_O)
        else $error("Ack dropped while selected.");
    ack_release_a:
        assert property (ACK_N_OE && CE_N |=> !ACK_N_OE && !CB_DATA_OE)
        else $error("Ack not released after deselect.");
    read_drive_a:
        assert property ($rose(ACK_N_OE) && READ_NOT_WRITE |-> CB_DATA_OE)
        else $error("Read data not driven with ack.");
    write_quiet_a:
        assert property (ACK_N_OE && !READ_NOT_WRITE |-> !CB_DATA_OE)
        else $error("Data driven during a write.");
    read_parity_a:
        assert property (CB_DATA_OE |-> ^{CB_PARITY_O, CB_DATA_O} == 1'b1)
        else $error("Read parity not odd.");
    rsvd_zero_a:
        assert property (CB_DATA_OE && CB_ADDR >= RSVD_LOW_OFS
            |-> CB_DATA_O == 8'h00)
        else $error("Reserved location read nonzero.");
endmodule // phyp_port_asserts

bind phyp_port phyp_port_asserts chk (.CLOCK, .NRST, .TX_ENABLE_POLARITY,
    .PMD_TX_ENABLE_OUT, .INDICATE_PARITY, .INDICATE_CTL_FLAG,
    .INDICATE_SYMBOLS, .CE_N, .READ_NOT_WRITE, .CB_ADDR, .CB_DATA_I,
    .CB_DATA_O, .CB_DATA_OE, .CB_PARITY_I, .CB_PARITY_O, .ACK_N_O,
    .ACK_N_OE);

// ### tb/phyp_port_tb.sv
// Bench for the port block: control bus, enable table, both paths.
// Assumes the partner model drives the receive line and carrier.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fails++; $display("Error %s expected %h seen %h", nm, e, g); end end
module phyp_port_tb;
    import phyp_pkg::*;
    logic CLOCK = 0, NRST = 0, TX_ENABLE_POLARITY = 0, CE_N = 1;
    logic READ_NOT_WRITE = 1, CB_PARITY_I = 0, REQUEST_VALID = 0;
    logic REQUEST_PARITY = 0, REQUEST_CTL_FLAG = 0, rx_on = 0, rx_ctl = 0;
    logic [5:0] CB_ADDR = 6'h00;
    logic [7:0] CB_DATA_I = 8'h00, REQUEST_SYMBOLS = 8'h00, rx_sym = 8'h00;
    logic [7:0] q;
    logic [9:0] sh;
    wire SERIAL_RX_IN, CARRIER_PRESENT_IN, SERIAL_TX_OUT, PMD_TX_ENABLE_OUT;
    wire INDICATE_PARITY, INDICATE_CTL_FLAG, REQUEST_READY, CB_DATA_OE;
    wire CB_PARITY_O, CB_PARITY_OE, ACK_N_O, ACK_N_OE;
    wire [7:0] INDICATE_SYMBOLS, CB_DATA_O;
    int fails = 0, checks_done = 0, n;
    logic [8:0] pairs [3] = '{9'h13c, 9'h0a5, 9'h000};

    phyp_port dut (.CLOCK, .NRST, .SERIAL_RX_IN, .CARRIER_PRESENT_IN,
        .SERIAL_TX_OUT, .TX_ENABLE_POLARITY, .PMD_TX_ENABLE_OUT,
        .INDICATE_PARITY, .INDICATE_CTL_FLAG, .INDICATE_SYMBOLS,
        .REQUEST_VALID, .REQUEST_READY, .REQUEST_PARITY, .REQUEST_CTL_FLAG,
        .REQUEST_SYMBOLS, .CE_N, .READ_NOT_WRITE, .CB_ADDR, .CB_DATA_I,
        .CB_DATA_O, .CB_DATA_OE, .CB_PARITY_I, .CB_PARITY_O, .CB_PARITY_OE,
        .ACK_N_O, .ACK_N_OE);
    phyp_partner far (.clk(CLOCK), .on(rx_on), .ctl(rx_ctl), .sym(rx_sym),
        .rx(SERIAL_RX_IN), .carrier(CARRIER_PRESENT_IN));

    // 125 MHz clock.
    initial forever #4 CLOCK = ~CLOCK;

    task automatic print_verdict();
        if (fails == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // One bus cycle; released lines carry the inverse of the last data.
    task automatic cb(input logic rnw, input logic [5:0] a,
        input logic [7:0] d, input logic bad);
        CE_N = 0;
        READ_NOT_WRITE = rnw;
        CB_ADDR = a;
        CB_DATA_I = d;
        CB_PARITY_I = ~^d ^ bad;
        n = 0;
        do begin @(posedge CLOCK); #1; n++; end
        while (ACK_N_OE !== 1'b1 && n < 20);
        if (n >= 20) begin fails++; print_verdict(); end
        // Hold the request through the edge that samples the ack high.
        @(posedge CLOCK); #1;
        q = CB_DATA_O;
        `CHK("cb_par_oe", rnw, CB_PARITY_OE)
        CE_N = 1;
        CB_DATA_I = ~d;
        CB_PARITY_I = ~CB_PARITY_I;
        @(posedge CLOCK); #1;
    endtask

    task automatic rd(input string nm, input logic [5:0] a,
        input logic [7:0] e);
        cb(1'b1, a, 8'h00, 1'b0);
        `CHK(nm, e, q)
    endtask

    // Offers one pair and waits for the edge that takes it.
    task automatic push(input logic c, input logic [7:0] s, input logic bad);
        REQUEST_VALID = 1;
        REQUEST_CTL_FLAG = c;
        REQUEST_SYMBOLS = s;
        REQUEST_PARITY = ~^{c, s} ^ bad;
        for (n = 0; n < 50 && REQUEST_READY !== 1'b1; n++) @(posedge CLOCK) #1;
        if (n >= 50) begin fails++; print_verdict(); end
        @(posedge CLOCK); #1;
        REQUEST_VALID = 0;
    endtask

    initial begin
        repeat (4) @(posedge CLOCK);
        #1 NRST = 1;
        repeat (2) @(posedge CLOCK) #1;
        `CHK("enable_reset", 1'b1, PMD_TX_ENABLE_OUT)
        rd("mode_rst", MODE_OFS, 8'h00);
        rd("state_rst", TX_STATE_OFS, 8'h00);
        rd("rsvd_low", RSVD_LOW_OFS, 8'h00);
        rd("rsvd_high", RSVD_HIGH_OFS, 8'h00);
        rd("unmapped", 6'h20, 8'h00);
        // Every permit and polarity combination, with the state off and at code 5.
        for (int i = 0; i < 8; i++) begin
            cb(1'b0, MODE_OFS, {7'h00, i[2]}, 1'b0);
            cb(1'b0, TX_STATE_OFS, i[1] ? 8'h05 : 8'h00, 1'b0);
            TX_ENABLE_POLARITY = i[0];
            repeat (3) @(posedge CLOCK) #1;
            `CHK("enable", (i[2] & i[1]) ? i[0] : ~i[0], PMD_TX_ENABLE_OUT)
        end
        cb(1'b0, MODE_OFS, 8'h00, 1'b1);
        rd("mode_badpar", MODE_OFS, 8'h01);
        rd("state", TX_STATE_OFS, 8'h05);
        // Received pairs, then a dead line gives the idle pair.
        for (int i = 0; i < 4; i++) begin
            {rx_ctl, rx_sym} = (i < 3) ? pairs[i] : 9'h1ff;
            rx_on = (i < 3);
            repeat (40) @(posedge CLOCK) #1;
            `CHK("ind_sym", rx_sym, INDICATE_SYMBOLS)
            `CHK("ind_ctl", rx_ctl, INDICATE_CTL_FLAG)
            `CHK("ind_par", ~^{rx_ctl, rx_sym}, INDICATE_PARITY)
        end
        // Back-to-back requests until the buffer refuses.
        // The filler pair must carry good parity or every one is dropped.
        REQUEST_PARITY = ~^{REQUEST_CTL_FLAG, REQUEST_SYMBOLS};
        REQUEST_VALID = 1;
        for (n = 0; n < 200 && REQUEST_READY !== 1'b0; n++)
            @(posedge CLOCK) #1;
        REQUEST_VALID = 0;
        `CHK("fill_count", 1'b1, n >= 32 && n < 200)
        rd("stat_full", STATUS_OFS, 8'h04);
        for (int k = 0; k < 200 && q[STAT_EMPTY_BIT] !== 1'b1; k++)
            cb(1'b1, STATUS_OFS, 8'h00, 1'b0);
        `CHK("stat_empty", 1'b1, q[STAT_EMPTY_BIT])
        push(1'b1, 8'h11, 1'b1);
        rd("stat_perr", STATUS_OFS, 8'h0a);
        cb(1'b0, STATUS_OFS, 8'h02, 1'b0);
        rd("stat_clr", STATUS_OFS, 8'h08);
        push(1'b0, 8'h5a, 1'b0);
        sh = 10'h000;
        for (n = 0; n < 300 && sh !== 10'b0010110101; n++) begin
            @(posedge CLOCK) #1;
            sh = {sh[8:0], SERIAL_TX_OUT};
        end
        `CHK("tx_frame", 10'b0010110101, sh)
        print_verdict();
    end

    // Hang guard.
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule // phyp_port_tb
